// *** design/bmf_regs_map.svh ***
// Register map, field layout and reset values of the bus-management
// initial-value and fairness register bank.
// Assumes a plain register port with byte offsets on a 32-bit data word.
//
// Behaviour
// - Both initial masks reset to ones only.
// - Reset events copy upper mask into CSR.
// - Same events copy lower mask into CSR.
// - Priority requests per interval capped by field.
// - Priority-request limit resets to zero.
// - Fairness bits 31-8 read zero, reserved.
`ifndef BMF_REGS_MAP_SVH
`define BMF_REGS_MAP_SVH

`define BMF_OFS_INIT_UPPER   8'hB4
`define BMF_OFS_INIT_LOWER   8'hB8
`define BMF_OFS_FAIRNESS     8'hDC
`define BMF_OFS_CSR_UPPER    8'hC0
`define BMF_OFS_CSR_LOWER    8'hC4
`define BMF_OFS_FAIR_STATUS  8'hC8

`define BMF_INIT_MASK_RST    32'hFFFFFFFF
`define BMF_PRI_LIMIT_RST    8'h00
`define BMF_PRI_LIMIT_MSB    7
`define BMF_PRI_LIMIT_LSB    0

`endif

// *** design/bmf_pkg.sv ***
// Types shared by the bus-management initial-value register bank.
// Assumes the map header supplies every offset and reset value.
package bmf_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bmf_bus_req_s;

  typedef struct packed {
    logic globalReset;
    logic fundamentalReset;
    logic portReset;
    logic busReset;
  } bmf_reload_s;

  typedef enum logic [1:0] {
    BMF_FAIR_IDLE  = 2'b00,
    BMF_FAIR_OPEN  = 2'b01,
    BMF_FAIR_SPENT = 2'b10
  } bmf_fair_e;

endpackage

// *** design/bmf_mask_pair.sv ***
// One initial-value mask and the channels-available CSR it loads.
// Assumes reload is a one-cycle pulse from the reset-event combiner.
`timescale 1ns/1ps
`include "bmf_regs_map.svh"
module bmf_mask_pair (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        write,
  input  wire logic [31:0] wdata,
  input  wire logic        reload,
  output logic      [31:0] initMask,
  output logic      [31:0] csrMask
);

  // A bus reset is not a register reset, so the stored mask keeps its
  // value here and only the CSR copy is refreshed.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      initMask <= `BMF_INIT_MASK_RST;
    end else if (write) begin
      initMask <= wdata;
    end
  end

  // Reload copies the value as stored before a same-cycle write.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csrMask <= `BMF_INIT_MASK_RST;
    end else if (reload) begin
      csrMask <= initMask;
    end
  end

endmodule

// *** design/bmf_regs.sv ***
// Top of the bus-management initial-value and fairness register bank.
// Assumes synchronous inputs on clk_sys and a master that never waits.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "bmf_regs_map.svh"
module bmf_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire bmf_pkg::bmf_bus_req_s busReq,
  output logic               [31:0] rdata,
  input  wire bmf_pkg::bmf_reload_s reloadIn,
  input  wire logic                 fairIntervalStart,
  input  wire logic                 prioWant,
  output logic                      prioGrant,
  output logic               [31:0] csrChanUpper,
  output logic               [31:0] csrChanLower,
  output logic                [7:0] priLimit
);

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  logic        wrUpper;
  logic        wrLower;
  logic        wrFair;
  logic        reload;
  logic [31:0] initUpper;
  logic [31:0] initLower;
  logic [7:0]  priLimit_r;
  logic [7:0]  priUsed_r;
  logic [7:0]  priUsed_nxt;
  logic [7:0]  priCap_r;
  logic [31:0] rdata_nxt;
  bmf_pkg::bmf_fair_e fairState_r;
  bmf_pkg::bmf_fair_e fairState_nxt;

  assign wrUpper = busReq.wr && busReq.addr == `BMF_OFS_INIT_UPPER;
  assign wrLower = busReq.wr && busReq.addr == `BMF_OFS_INIT_LOWER;
  assign wrFair  = busReq.wr && busReq.addr == `BMF_OFS_FAIRNESS;
  assign reload  = reloadIn.globalReset | reloadIn.fundamentalReset |
                   reloadIn.portReset | reloadIn.busReset;

  // --------------------------------------------------------------------
  // Channel masks
  // --------------------------------------------------------------------
  bmf_mask_pair upperPair (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .write    (wrUpper),
    .wdata    (busReq.wdata),
    .reload   (reload),
    .initMask (initUpper),
    .csrMask  (csrChanUpper)
  );

  bmf_mask_pair lowerPair (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .write    (wrLower),
    .wdata    (busReq.wdata),
    .reload   (reload),
    .initMask (initLower),
    .csrMask  (csrChanLower)
  );

  // --------------------------------------------------------------------
  // Fairness limit
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      priLimit_r <= `BMF_PRI_LIMIT_RST;
    end else if (wrFair) begin
      priLimit_r <= busReq.wdata[`BMF_PRI_LIMIT_MSB:`BMF_PRI_LIMIT_LSB];
    end
  end

  assign priLimit = priLimit_r;

  // --------------------------------------------------------------------
  // Priority request budget per fairness interval
  // --------------------------------------------------------------------
  // A limit of zero keeps the state idle, so no priority grant is given.
  always_comb begin
    fairState_nxt = fairState_r;
    priUsed_nxt   = priUsed_r;
    if (fairIntervalStart) begin
      priUsed_nxt   = 8'h00;
      fairState_nxt = (priLimit_r == 8'h00) ? bmf_pkg::BMF_FAIR_IDLE
                                            : bmf_pkg::BMF_FAIR_OPEN;
    end else begin
      unique case (fairState_r)
        bmf_pkg::BMF_FAIR_IDLE: begin
          fairState_nxt = bmf_pkg::BMF_FAIR_IDLE;
        end
        bmf_pkg::BMF_FAIR_OPEN: begin
          if (prioWant) begin
            priUsed_nxt = priUsed_r + 8'h01;
            if (priUsed_nxt >= priCap_r) begin
              fairState_nxt = bmf_pkg::BMF_FAIR_SPENT;
            end
          end
        end
        bmf_pkg::BMF_FAIR_SPENT: begin
          fairState_nxt = bmf_pkg::BMF_FAIR_SPENT;
        end
        default: begin
          fairState_nxt = bmf_pkg::BMF_FAIR_IDLE;
        end
      endcase
    end
  end

  // The cap is taken when the interval opens, so a limit written while an
  // interval runs only governs the next interval.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      priCap_r <= `BMF_PRI_LIMIT_RST;
    end else if (fairIntervalStart) begin
      priCap_r <= priLimit_r;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fairState_r <= bmf_pkg::BMF_FAIR_IDLE;
    end else begin
      fairState_r <= fairState_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      priUsed_r <= 8'h00;
    end else begin
      priUsed_r <= priUsed_nxt;
    end
  end

  // Grant is combinational so the arbiter sees it in the request cycle.
  assign prioGrant = prioWant && !fairIntervalStart &&
                     fairState_r == bmf_pkg::BMF_FAIR_OPEN;

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h00000000;
    unique case (busReq.addr)
      `BMF_OFS_INIT_UPPER:  rdata_nxt = initUpper;
      `BMF_OFS_INIT_LOWER:  rdata_nxt = initLower;
      `BMF_OFS_FAIRNESS:    rdata_nxt = {24'h000000, priLimit_r};
      `BMF_OFS_CSR_UPPER:   rdata_nxt = csrChanUpper;
      `BMF_OFS_CSR_LOWER:   rdata_nxt = csrChanLower;
      `BMF_OFS_FAIR_STATUS: rdata_nxt = {22'h0, fairState_r,
                                         priUsed_r};
      default:              rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (busReq.rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule

// *** verif/bmf_regs_properties.sv ***
// Checker for the register bank, bound to bmf_regs.
// Assumes one clock and an active-high async reset.
`timescale 1ns/1ps
module bmf_chk (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire bmf_pkg::bmf_bus_req_s busReq,
  input wire bmf_pkg::bmf_reload_s  reloadIn,
  input wire logic                  fairIntervalStart,
  input wire logic                  prioWant,
  input wire logic                  prioGrant,
  input wire logic           [31:0] rdata,
  input wire logic           [31:0] csrChanUpper,
  input wire logic           [31:0] csrChanLower,
  input wire logic            [7:0] priLimit
);
  logic [31:0] upR, loR;
  logic [7:0]  limR, useR;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Shadows of the stored masks, the interval cap and the grant count, so loads are judged independently.
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) upR <= 32'hFFFFFFFF;
    else if (busReq.wr && busReq.addr == 8'hB4) upR <= busReq.wdata;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) loR <= 32'hFFFFFFFF;
    else if (busReq.wr && busReq.addr == 8'hB8) loR <= busReq.wdata;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) limR <= 8'h00;
    else if (fairIntervalStart) limR <= priLimit;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) useR <= 8'h00;
    else if (fairIntervalStart) useR <= 8'h00;
    else if (prioGrant) useR <= useR + 8'h01;
  sequence reload_s;
    |reloadIn;
  endsequence
  up_load_a: assert property (reload_s |=> csrChanUpper == $past(upR))
    else $error("upper CSR not loaded");
  lo_load_a: assert property (reload_s |=> csrChanLower == $past(loR))
    else $error("lower CSR not loaded");
  csr_hold_a: assert property (!(|reloadIn) |=> $stable(csrChanUpper)
    && $stable(csrChanLower)) else $error("CSR moved without reload");
  rst_val_a: assert property ($fell(rst) |-> priLimit == 8'h00
    && csrChanUpper == '1 && csrChanLower == '1) else $error("bad reset");
  mask_rd_a: assert property (busReq.rd && busReq.addr == 8'hB4
    |=> rdata == upR) else $error("mask read wrong");
  lim_rd_a: assert property (busReq.rd && busReq.addr == 8'hDC
    |=> rdata == {24'h0, priLimit}) else $error("fairness read wrong");
  start_ng_a: assert property (fairIntervalStart |-> !prioGrant)
    else $error("grant in start cycle");
  grant_cap_a: assert property (prioGrant |-> prioWant
    && useR < limR) else $error("grant over limit");
endmodule

// *** verif/bmf_phy_model.sv ***
// Requester on the arbitration side: opens an interval, asks ten times.
// Assumes go is a one-cycle pulse from the bench.
`timescale 1ns/1ps
module bmf_phy_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic       prioGrant,
  output logic            fairIntervalStart,
  output logic            prioWant,
  output logic      [7:0] grants
);
  logic [3:0] left;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) begin
      fairIntervalStart <= 1'b0;
      prioWant <= 1'b0;
      left <= 4'h0;
      grants <= 8'h00;
    end else begin
      fairIntervalStart <= go;
      left <= go ? 4'hA : left - 4'(left != 4'h0);
      prioWant <= left != 4'h0;
      grants <= go ? 8'h00 : grants + 8'(prioWant & prioGrant);
    end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for bmf_regs with the requester model.
// Assumes the bench alone drives the register port and reload inputs.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0, rst = 1, go = 0, rdV = 0, fis, want, grant;
  bmf_pkg::bmf_bus_req_s busReq = '0;
  bmf_pkg::bmf_reload_s reloadIn = '0;
  logic [31:0] rdata, csrU, csrL, x, p = '1, pl = '1, s = 32'hF050, q[$];
  logic [7:0] lim, grants, lv[4] = '{8'h00, 8'h01, 8'h03, 8'h0C};
  int error_cnt = 0, checked = 0;
  bmf_regs uut (.clk_sys(clk_sys), .rst(rst), .busReq(busReq),
    .rdata(rdata), .reloadIn(reloadIn), .fairIntervalStart(fis),
    .prioWant(want), .prioGrant(grant), .csrChanUpper(csrU),
    .csrChanLower(csrL), .priLimit(lim));
  bmf_phy_model phy (.clk_sys(clk_sys), .rst(rst), .go(go),
    .prioGrant(grant), .fairIntervalStart(fis), .prioWant(want),
    .grants(grants));
  initial forever #20 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(string n, logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    busReq <= '{a, d, w, !w};
    @(posedge clk_sys);
    busReq <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic print_verdict();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) rdV <= busReq.rd;
  always @(negedge clk_sys)
    if (rdV) chk("rdata", rdata, q.pop_front());
  // Run needs about 140 cycles; the 2000-cycle limit, over fourteen times that, means a hang.
  initial begin
    #80000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'hB4, 32'hFFFFFFFF);
    rd(8'hDC, 32'h0);
    for (int i = 0; i < 4; i++) begin
      x = xs();
      bus(1'b1, 8'hB4, x);
      bus(1'b1, 8'hB8, ~x);
      chk("csrU", csrU, p);
      chk("csrL", csrL, pl);
      reloadIn[i] <= 1'b1;
      @(posedge clk_sys);
      reloadIn <= '0;
      @(posedge clk_sys);
      chk("csrU", csrU, x);
      chk("csrL", csrL, ~x);
      rd(8'hB8, ~x);
      rd(8'hC0, x);
      rd(8'hC4, ~x);
      p = x;
      pl = ~x;
    end
    $display("masks done");
    bus(1'b1, 8'hDC, 32'hFFFFFFFF);
    rd(8'hDC, 32'hFF);
    foreach (lv[k]) begin
      bus(1'b1, 8'hDC, {24'h0, lv[k]});
      chk("lim", {24'h0, lim}, {24'h0, lv[k]});
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      // A limit written inside the interval must not widen its budget.
      bus(1'b1, 8'hDC, 32'h000000FF);
      repeat (12) @(posedge clk_sys);
      x = (lv[k] > 8'hA) ? 32'h0000000A : {24'h0, lv[k]};
      chk("grants", {24'h0, grants}, x);
    end
    rd(8'hC8, {22'h0, bmf_pkg::BMF_FAIR_OPEN, 8'h0A});
    $display("fairness done");
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'hB4, 32'hFFFFFFFF);
    rd(8'hDC, 32'h0);
    $display("reset done");
    print_verdict();
  end
endmodule
bind bmf_regs bmf_chk props (.clk_sys(clk_sys), .rst(rst),
  .busReq(busReq), .reloadIn(reloadIn), .priLimit(priLimit),
  .fairIntervalStart(fairIntervalStart), .prioWant(prioWant),
  .prioGrant(prioGrant), .rdata(rdata),
  .csrChanUpper(csrChanUpper), .csrChanLower(csrChanLower));
